// >>> core/occ_ctrl.v
// octal output channel control: serial command, protection, diagnostics
//
// Contract
// (RL1) each of eight channels follows its last written serial on/off bit
// (RL2) per-channel protection choice: filtered switch-off or linear limiting
// (RL3) after power-up every channel uses filtered switch-off protection
// (RL4) over-temperature handled separately for each channel
// (RL5) low-side channel commanded off: open-load and short-to-ground check
// (RL6) high-side channel commanded off: open-load and short-to-battery check
// (RL7) channels six to eight on when serial bit or discrete enable is high
// (RL8) open discrete enable reads low, leaving serial control only
// (RL9) reset pin low clears all registers and turns every output off
// (RL10) open reset pin reads inactive high
// (RL11) output mode: bit one turns its channel on, bit zero first channel
// (RL12) protection mode: bit one selects linear limiting for its channel
// (RL13) diagnostic mode: bit one selects latched fault reporting
// (RL14) power-on: all channels off, diagnostics unlatched
// (RL15) settings change only after a complete valid command word
// (RL16) reset pin acts at once on outputs, release is synchronised
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.vh"

module occ_ctrl #(
    parameter RESTART_CYC = `OCC_RESTART_MS * 1000 * `OCC_CLK_MHZ
) (
    input wire mclk,
    input wire rst,
    input wire reset_n,
    input wire sclk,
    input wire cs_n,
    input wire di,
    output reg do_ff,
    output reg do_oe_ff,
    input wire ch6_discrete_enable,
    input wire ch7_discrete_enable,
    input wire ch8_discrete_enable,
    input wire [7:0] high_side,
    input wire [7:0] over_temp,
    input wire [7:0] oc_sense,
    input wire [7:0] off_diag_fault,
    output reg [7:0] driver_channels,
    output reg [7:0] cur_limit_en,
    output reg [7:0] diag_gnd_en,
    output reg [7:0] diag_bat_en,
    input wire [4:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    output reg irq
);

// ****************************************
// timing
// ****************************************
// least filter time, rounded up to whole cycles
localparam [9:0] OC_FILT_CYC = `OCC_OC_FILT_CYC;

// ****************************************
// reset pin: async assert, synchronised release
// ****************************************
reg rsn_meta_ff;
reg rsn_ff;
wire lrst;

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        rsn_meta_ff <= 1'b0; // RL16
        rsn_ff <= 1'b0;
    end
    else
    begin
        rsn_meta_ff <= 1'b1;
        rsn_ff <= rsn_meta_ff; // RL16
    end
end

// an open pin is pulled high by the pad, so reset_n idles high
assign lrst = rst | ~rsn_ff; // RL9 RL10

// ****************************************
// pin synchronisers
// ****************************************
wire [37:0] pin_l;
wire sclk_l;
wire cs_l;
wire di_l;
wire [2:0] en_l;
wire [7:0] hs_l;
wire [7:0] ot_l;
wire [7:0] oc_l;
wire [7:0] od_l;

// open discrete enables are pulled low by the pad
occ_sync #(
    .W(38),
    .RST_VAL({35'h0, 3'h6})
) u_sync (
    .mclk(mclk),
    .rst(lrst),
    .async_in({od_l_src(off_diag_fault), oc_sense, over_temp, high_side,
        ch8_discrete_enable, ch7_discrete_enable, ch6_discrete_enable,
        cs_n, sclk, di}),
    .level_ff(pin_l)
);

function [7:0] od_l_src;
    input [7:0] v;
    begin
        od_l_src = v;
    end
endfunction

assign di_l = pin_l[0];
assign sclk_l = pin_l[1];
assign cs_l = pin_l[2];
assign en_l = pin_l[5:3]; // RL8
assign hs_l = pin_l[13:6];
assign ot_l = pin_l[21:14];
assign oc_l = pin_l[29:22];
assign od_l = pin_l[37:30];

// ****************************************
// serial link
// ****************************************
reg sclk_q_ff;
reg cs_q_ff;
reg [15:0] tx_ff;
reg [15:0] rx_ff;
reg [15:0] word_ff;
reg [3:0] bit_cnt_ff;
reg got_word_ff;
wire sclk_rise;
wire sclk_fall;
wire cs_fall;
wire cs_rise;
wire frame_ok;
wire [15:0] fault_w;

// true when the key matches and the mode is one of the three known
function key_ok;
    input [15:0] w;
    begin
        key_ok = (w[15:12] == `OCC_KEY) &&
            ((w[11:8] == `OCC_MODE_OUT) || (w[11:8] == `OCC_MODE_DIAG) ||
            (w[11:8] == `OCC_MODE_PROT));
    end
endfunction

assign sclk_rise = sclk_l & ~sclk_q_ff;
assign sclk_fall = ~sclk_l & sclk_q_ff;
assign cs_fall = ~cs_l & cs_q_ff;
assign cs_rise = cs_l & ~cs_q_ff;
// whole words only, and the first word carries the key
assign frame_ok = cs_rise & got_word_ff & (bit_cnt_ff == 4'h0) & key_ok(word_ff); // RL15

always @(posedge mclk)
begin
    if (lrst)
    begin
        sclk_q_ff <= 1'b1;
        cs_q_ff <= 1'b1;
        tx_ff <= 16'h0000;
        rx_ff <= 16'h0000;
        word_ff <= 16'h0000;
        bit_cnt_ff <= 4'h0;
        got_word_ff <= 1'b0;
        do_ff <= 1'b0;
        do_oe_ff <= 1'b0;
    end
    else
    begin
        sclk_q_ff <= sclk_l;
        cs_q_ff <= cs_l;
        if (cs_fall)
        begin
            tx_ff <= fault_w;
            do_ff <= fault_w[0];
            do_oe_ff <= 1'b1;
            bit_cnt_ff <= 4'h0;
            got_word_ff <= 1'b0;
        end
        else if (cs_rise)
        begin
            do_oe_ff <= 1'b0;
        end
        else if (!cs_l && sclk_rise)
        begin
            // lsb first; after the fault word the input wraps to the output
            tx_ff <= {di_l, tx_ff[15:1]};
            rx_ff <= {di_l, rx_ff[15:1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'hf && !got_word_ff)
            begin
                word_ff <= {di_l, rx_ff[15:1]};
                got_word_ff <= 1'b1;
            end
        end
        else if (!cs_l && sclk_fall)
        begin
            do_ff <= tx_ff[0];
        end
    end
end

// ****************************************
// command, protection and diagnostic settings
// ****************************************
reg [7:0] out_cmd_ff;
reg [7:0] prot_ff;
reg [7:0] diag_ff;

always @(posedge mclk)
begin
    if (lrst)
    begin
        out_cmd_ff <= `OCC_RST_OUT_CMD; // RL9 RL14
        prot_ff <= `OCC_RST_PROT; // RL3
        diag_ff <= `OCC_RST_DIAG; // RL14
    end
    else if (frame_ok)
    begin
        case (word_ff[11:8])
            `OCC_MODE_OUT: out_cmd_ff <= word_ff[7:0]; // RL1 RL11
            `OCC_MODE_PROT: prot_ff <= word_ff[7:0]; // RL2 RL12
            `OCC_MODE_DIAG: diag_ff <= word_ff[7:0]; // RL13
            default: out_cmd_ff <= out_cmd_ff;
        endcase
    end
end

// ****************************************
// overcurrent filter and restart
// ****************************************
reg [9:0] oc_cnt_ff [0:7];
reg [31:0] res_cnt_ff [0:7];
reg [7:0] oc_off_ff;
reg [7:0] oc_trip_ff;
reg [7:0] oc_new;
integer i;
integer j;

always @*
begin
    for (i = 0; i < 8; i = i + 1)
    begin
        oc_new[i] = oc_l[i] & driver_channels[i] & ~prot_ff[i] &
            (oc_cnt_ff[i] == OC_FILT_CYC - 10'h1);
    end
end

always @(posedge mclk)
begin
    for (j = 0; j < 8; j = j + 1)
    begin
        if (lrst)
        begin
            oc_cnt_ff[j] <= 10'h000;
            res_cnt_ff[j] <= 32'h0;
            oc_off_ff[j] <= 1'b0;
            oc_trip_ff[j] <= 1'b0;
        end
        else
        begin
            // filtered trip: current must stay high for the whole window
            if (!oc_l[j] || !driver_channels[j])
                oc_cnt_ff[j] <= 10'h000;
            else if (oc_cnt_ff[j] != OC_FILT_CYC - 10'h1)
                oc_cnt_ff[j] <= oc_cnt_ff[j] + 10'h001;
            oc_trip_ff[j] <= oc_l[j] & driver_channels[j] &
                (oc_cnt_ff[j] == OC_FILT_CYC - 10'h1);
            // linear mode never switches off, the stage limits instead
            if (oc_new[j])
            begin
                oc_off_ff[j] <= 1'b1; // RL2
                res_cnt_ff[j] <= RESTART_CYC - 1;
            end
            else if (oc_off_ff[j])
            begin
                if (res_cnt_ff[j] == 32'h0)
                    oc_off_ff[j] <= 1'b0;
                else
                    res_cnt_ff[j] <= res_cnt_ff[j] - 32'h1;
            end
        end
    end
end

// ****************************************
// output drive
// ****************************************
reg force_off_ff;
wire [7:0] want;
wire [7:0] nxt_drv;

assign want = out_cmd_ff | {en_l, 5'h00}; // RL1 RL7
// each channel is gated by its own temperature flag, never by another channel's
assign nxt_drv = want & ~ot_l & ~oc_off_ff & {8{~force_off_ff}}; // RL4

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        driver_channels <= 8'h00; // RL16
        cur_limit_en <= 8'h00;
        diag_gnd_en <= 8'h00;
        diag_bat_en <= 8'h00;
    end
    else if (lrst)
    begin
        driver_channels <= 8'h00; // RL9
        cur_limit_en <= 8'h00;
        diag_gnd_en <= 8'h00;
        diag_bat_en <= 8'h00;
    end
    else
    begin
        driver_channels <= nxt_drv;
        cur_limit_en <= prot_ff; // RL2
        diag_gnd_en <= ~want & ~hs_l; // RL5
        diag_bat_en <= ~want & hs_l; // RL6
    end
end

// ****************************************
// fault register
// ****************************************
reg [15:0] fault_ff;
wire [15:0] fault_live;
wire [15:0] latch_sel;
wire [15:0] nxt_fault;

// high byte on-state faults, low byte off-state diagnosis
assign fault_live = {oc_trip_ff | ot_l, od_l & ~want};
assign latch_sel = {diag_ff, diag_ff};
// set beats the clear from a valid frame
assign nxt_fault = (latch_sel & ((frame_ok ? 16'h0000 : fault_ff) | fault_live)) |
    (~latch_sel & fault_live); // RL13
assign fault_w = fault_ff;

always @(posedge mclk)
begin
    if (lrst)
        fault_ff <= 16'h0000;
    else
        fault_ff <= nxt_fault;
end

// ****************************************
// interrupts
// ****************************************
reg [4:0] irq_stat_ff;
reg [4:0] irq_mask_ff;
reg [7:0] ot_q_ff;
wire [4:0] ev;
wire [4:0] nxt_stat;

assign ev = {|(nxt_fault & ~fault_ff), |(ot_l & ~ot_q_ff), |oc_new,
    cs_rise & ~frame_ok, frame_ok};
assign nxt_stat = (irq_stat_ff & ~((wr && addr == `OCC_REG_IRQ_STAT) ?
    wdata[4:0] : 5'h00)) | ev;

always @(posedge mclk)
begin
    if (lrst)
    begin
        irq_stat_ff <= 5'h00;
        irq_mask_ff <= `OCC_RST_MASK;
        force_off_ff <= `OCC_RST_CTRL;
        ot_q_ff <= 8'h00;
        irq <= 1'b0;
    end
    else
    begin
        ot_q_ff <= ot_l;
        irq_stat_ff <= nxt_stat;
        irq <= |(nxt_stat & irq_mask_ff);
        if (wr && addr == `OCC_REG_IRQ_MASK)
            irq_mask_ff <= wdata[4:0];
        if (wr && addr == `OCC_REG_CTRL)
            force_off_ff <= wdata[`OCC_CTRL_FORCE_OFF];
    end
end

// ****************************************
// register read
// ****************************************
reg [31:0] rd_mux;

always @*
begin
    case (addr)
        `OCC_REG_OUT_CMD: rd_mux = {24'h0, out_cmd_ff};
        `OCC_REG_PROT: rd_mux = {24'h0, prot_ff};
        `OCC_REG_DIAG: rd_mux = {24'h0, diag_ff};
        `OCC_REG_FAULT: rd_mux = {16'h0, fault_ff};
        `OCC_REG_DRIVE: rd_mux = {24'h0, driver_channels};
        `OCC_REG_IRQ_STAT: rd_mux = {27'h0, irq_stat_ff};
        `OCC_REG_IRQ_MASK: rd_mux = {27'h0, irq_mask_ff};
        `OCC_REG_CTRL: rd_mux = {31'h0, force_off_ff};
        default: rd_mux = 32'h0;
    endcase
end

// data stand only in the cycle after the strobe
always @(posedge mclk)
begin
    if (lrst)
        rdata <= 32'h0;
    else
        rdata <= rd ? rd_mux : 32'h0;
end

endmodule // occ_ctrl

`default_nettype wire

// >>> core/occ_map.vh
// constants of the octal output channel control block
`ifndef OCC_MAP_VH
`define OCC_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define OCC_REG_OUT_CMD 5'h00
`define OCC_REG_PROT 5'h04
`define OCC_REG_DIAG 5'h08
`define OCC_REG_FAULT 5'h0c
`define OCC_REG_DRIVE 5'h10
`define OCC_REG_IRQ_STAT 5'h14
`define OCC_REG_IRQ_MASK 5'h18
`define OCC_REG_CTRL 5'h1c

// ****************************************
// field positions and reset values
// ****************************************
`define OCC_CTRL_FORCE_OFF 0
`define OCC_EV_FRAME_OK 0
`define OCC_EV_FRAME_BAD 1
`define OCC_EV_OC_OFF 2
`define OCC_EV_THERM 3
`define OCC_EV_FAULT 4
`define OCC_NUM_EV 5
`define OCC_RST_OUT_CMD 8'h00
`define OCC_RST_PROT 8'h00
`define OCC_RST_DIAG 8'h00
`define OCC_RST_MASK 5'h00
`define OCC_RST_CTRL 1'h0

// ****************************************
// command word layout
// ****************************************
`define OCC_WORD_BITS 16
`define OCC_KEY 4'ha
`define OCC_MODE_OUT 4'hc
`define OCC_MODE_DIAG 4'h3
`define OCC_MODE_PROT 4'ha

// ****************************************
// timing
// ****************************************
`define OCC_CLK_MHZ 100
`define OCC_OC_FILT_US 10
// ten microseconds at the core clock, in whole cycles
`define OCC_OC_FILT_CYC 10'h3e8
`define OCC_RESTART_MS 120

`endif

// >>> core/occ_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module occ_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire mclk,
    input wire rst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] level_ff
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;

// first stage feeds only the second stage
always @(posedge mclk)
begin
    if (rst)
    begin
        s1_ff <= RST_VAL;
        s2_ff <= RST_VAL;
        s3_ff <= RST_VAL;
        level_ff <= RST_VAL;
    end
    else
    begin
        s1_ff <= async_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        // a change counts only once stages two and three agree
        level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff ^ s3_ff));
    end
end

endmodule // occ_sync

`default_nettype wire

// >>> sim/occ_chk.sv
// assertion checker for the output channel control block
`timescale 1ns/1ns
`default_nettype none
module occ_chk (
    input wire mclk,
    input wire rst,
    input wire reset_n,
    input wire cs_n,
    input wire ch6_discrete_enable,
    input wire ch8_discrete_enable,
    input wire [7:0] high_side,
    input wire [7:0] oc_sense,
    input wire do_oe_ff,
    input wire [7:0] driver_channels,
    input wire [7:0] cur_limit_en,
    input wire [7:0] diag_gnd_en,
    input wire [7:0] diag_bat_en
);
    // ********
    // rules
    // ********
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_rst_clear: assert property (
        $fell(rst) |-> (driver_channels | cur_limit_en) == 8'h00)
        else $error("settings not clear after reset");
    a_pin_reset: assert property (
        !reset_n |-> (driver_channels | cur_limit_en) == 8'h00)
        else $error("reset pin low but outputs set");
    a_ch6_enable: assert property (
        (ch6_discrete_enable && reset_n && !oc_sense[5]) [*8] |-> driver_channels[5])
        else $error("channel six enable ignored");
    a_ch8_enable: assert property (
        (ch8_discrete_enable && reset_n && !oc_sense[7]) [*8] |-> driver_channels[7])
        else $error("channel eight enable ignored");
    a_low_diag: assert property (
        (high_side == 8'hff) [*6] |-> diag_gnd_en == 8'h00)
        else $error("ground check on high side channel");
    a_high_diag: assert property (
        (high_side == 8'h00) [*6] |-> diag_bat_en == 8'h00)
        else $error("battery check on low side channel");
    a_hold_settings: assert property (
        (cs_n && reset_n) [*8] |-> $stable(cur_limit_en))
        else $error("protection changed without frame");
    a_oe_frame: assert property (
        (!cs_n && reset_n) [*8] |-> do_oe_ff)
        else $error("data out not driven in frame");
endmodule // occ_chk
bind occ_ctrl occ_chk i_occ_chk (
    .mclk(mclk),
    .rst(rst),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .ch6_discrete_enable(ch6_discrete_enable),
    .ch8_discrete_enable(ch8_discrete_enable),
    .high_side(high_side),
    .oc_sense(oc_sense),
    .do_oe_ff(do_oe_ff),
    .driver_channels(driver_channels),
    .cur_limit_en(cur_limit_en),
    .diag_gnd_en(diag_gnd_en),
    .diag_bat_en(diag_bat_en)
);
`default_nettype wire

// >>> sim/occ_host.sv
// host model driving the serial link pins
`timescale 1ns/1ns
`default_nettype none
module occ_host (
    output logic sclk,
    output logic cs_n,
    output logic di,
    input wire do_ff,
    input wire do_oe_ff
);
    // ********
    // frame
    // ********
    logic last_do = 1'b0;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        di = 1'b1;
    end
    // released line shows the inverse, so a stale bit never passes
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        cs_n = 1'b0;
        #500;
        for (int i = 0; i < n; i++)
        begin
            di = tx[i];
            #62 sclk = 1'b1;
            rx[i] = do_oe_ff ? do_ff : ~last_do;
            last_do = rx[i];
            #63 sclk = 1'b0;
        end
        #62 cs_n = 1'b1;
        di = 1'b1;
    endtask
endmodule // occ_host
`default_nettype wire

// >>> sim/tb_occ_ctrl.sv
// self-checking bench for the output channel control block
`timescale 1ns/1ns
`default_nettype none
`include "occ_map.vh"
module tb_occ_ctrl;
    // ********
    // bench
    // ********
    localparam int RESTART = 50;
    logic mclk, rst, reset_n, wr, rd, irq, do_ff, do_oe, sclk, cs_n, di, e6, e7, e8;
    logic [7:0] hs, ot, oc, of, drv, lim, dgnd, dbat;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, rx;
    logic [4:0] rst_tab [6] = '{5'h00, 5'h04, 5'h08, 5'h10, 5'h18, 5'h1c};
    int num_errors = 0;
    int n_compared = 0;
    occ_ctrl #(.RESTART_CYC(RESTART)) i_occ_ctrl (.mclk(mclk), .rst(rst), .reset_n(reset_n),
        .sclk(sclk), .cs_n(cs_n), .di(di), .do_ff(do_ff), .do_oe_ff(do_oe),
        .ch6_discrete_enable(e6), .ch7_discrete_enable(e7), .ch8_discrete_enable(e8),
        .high_side(hs), .over_temp(ot), .oc_sense(oc), .off_diag_fault(of),
        .driver_channels(drv), .cur_limit_en(lim), .diag_gnd_en(dgnd), .diag_bat_en(dbat),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    occ_host i_occ_host (.sclk(sclk), .cs_n(cs_n), .di(di), .do_ff(do_ff), .do_oe_ff(do_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
        @(posedge mclk);
    endtask
    task automatic send(input logic [31:0] tx, input int n);
        i_occ_host.frame(tx, n, rx);
        wait_clk(12);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #300000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        {rst, reset_n, wr, rd, e6, e7, e8} = 7'b1000000;
        {hs, ot, oc, of} = {8'h0f, 24'h0};
        {addr, wdata} = 37'h0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        reset_n <= 1'b1;
        wait_clk(5);
        foreach (rst_tab[i]) rd_reg(rst_tab[i], 32'h0);
        check(drv, 8'h00);
        wr_reg(`OCC_REG_IRQ_MASK, 32'h1f);
        send(32'haca5, 16);
        check(drv, 8'ha5);
        check(dgnd, 8'h50);
        check(dbat, 8'h0a);
        check(irq, 1'b1);
        rd_reg(`OCC_REG_IRQ_STAT, 32'h01);
        wr_reg(`OCC_REG_IRQ_STAT, 32'h01);
        wait_clk(2);
        check(irq, 1'b0);
        hs <= 8'hff;
        wait_clk(10);
        check(dbat, 8'h5a);
        hs <= 8'h00;
        wait_clk(10);
        check(dgnd, 8'h5a);
        hs <= 8'h0f;
        // second word must not be applied
        send(32'hacff_aa3c, 32);
        check(rx[31:16], 16'haa3c);
        check(lim, 8'h3c);
        check(drv, 8'ha5);
        send(32'hac00, 15);
        send(32'h5c00, 16);
        check(drv, 8'ha5);
        rd_reg(`OCC_REG_IRQ_STAT, 32'h03);
        wr_reg(`OCC_REG_IRQ_STAT, 32'h1f);
        send(32'ha3ff, 16);
        rd_reg(`OCC_REG_DIAG, 32'hff);
        of <= 8'h02;
        ot <= 8'h01;
        wait_clk(10);
        of <= 8'h00;
        ot <= 8'h00;
        wait_clk(10);
        rd_reg(`OCC_REG_FAULT, 32'h0102);
        send(32'hac00, 16);
        check(rx, 32'h0102);
        for (int i = 0; i < 3; i++)
        begin
            {e8, e7, e6} <= 3'b001 << i;
            wait_clk(10);
            check(drv, 8'h20 << i);
        end
        {e8, e7, e6} <= 3'b000;
        wait_clk(10);
        check(drv, 8'h00);
        // switch-off mode, then linear mode on one overloaded channel
        send(32'hac01, 16);
        oc <= 8'h01;
        wait_clk(1030);
        check(drv, 8'h00);
        oc <= 8'h00;
        wait_clk(RESTART + 20);
        check(drv, 8'h01);
        send(32'haa01, 16);
        oc <= 8'h01;
        wait_clk(1030);
        check(drv, 8'h01);
        oc <= 8'h00;
        wr_reg(`OCC_REG_CTRL, 32'h1);
        wait_clk(2);
        check(drv, 8'h00);
        rd_reg(`OCC_REG_CTRL, 32'h1);
        wr_reg(`OCC_REG_CTRL, 32'h0);
        wait_clk(2);
        check(drv, 8'h01);
        reset_n <= 1'b0;
        #2;
        check({drv, lim}, 16'h0000);
        wait_clk(3);
        reset_n <= 1'b1;
        wait_clk(6);
        rd_reg(`OCC_REG_OUT_CMD, 32'h0);
        rd_reg(`OCC_REG_PROT, 32'h0);
        end_of_test();
    end
endmodule // tb_occ_ctrl
`default_nettype wire
